// *** verilog/itt_map.vh ***
// register map and constants of the interval tick timer
`ifndef ITT_MAP_VH
`define ITT_MAP_VH
`define ITT_ADDR_MODE 4'h0
`define ITT_ADDR_STATUS 4'h4
`define ITT_ADDR_ACK 4'h8
`define ITT_ADDR_PEEK 4'hC
`define ITT_ADDR_IRQ_STATUS 4'h10
`define ITT_ADDR_IRQ_ENABLE 4'h14
`define ITT_ADDR_IRQ_CLEAR 4'h18
`define ITT_MODE_RESET 32'h000FFFFF
`define ITT_LIMIT_RESET 20'hFFFFF
`define ITT_LIMIT_MSB 19
`define ITT_EN_BIT 24
`define ITT_IEN_BIT 25
`define ITT_TALLY_LSB 20
`define ITT_DIV 16
`define ITT_DIV_LAST 4'hF
`endif

// *** verilog/itt_timer.v ***
// periodic interval tick timer with classic wishbone slave
`timescale 1ns/1ps
`include "itt_map.vh"

// ==========================================================
// Summary of operation
// - 20-bit interval count and 12-bit tally advance on clock divided by 16.
// - interval count climbs from 0; at limit it returns to 0, tally increments.
// - each wrap sets tick flag; interrupt while flag and interrupt enable set.
// - writing a new limit neither resets nor restarts the counters.
// - reading acknowledge register returns count and tally, clears tally and flag.
// - reading peek register returns same fields without side effects.
// - enable changes take effect only while interval count is 0.
// - after disable, count runs to limit, wraps to 0 and then stops.
// - all counting halts while the core is in debug state.
// - period in divided ticks equals limit plus one.
// - mode holds limit in 19:0, enable bit 24, interrupt enable bit 25.
// - mode resets to 000FFFFF; status and value registers reset to zero.
module itt_timer (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [4:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg wb_err_o,
    input wire debug_halt_i,
    output reg tick_irq_o,
    output reg event_irq_o
);

// ==========================================================
// registers
reg [19:0] interval_limit;
reg timer_enable_bit;
reg tick_interrupt_enable;
reg [19:0] interval_count;
reg [11:0] overflow_tally;
reg tick_status_flag;
reg running;
reg [3:0] div_cnt;
reg evt_status;
reg evt_enable;
reg [31:0] next_rdata;
reg next_running;
reg [19:0] next_count;
reg [11:0] next_tally;
reg next_flag;
reg next_evt_status;
wire [31:0] mode_word;
wire [31:0] value_word;
wire [31:0] wmask;
wire [31:0] next_mode;
wire tick;
wire at_limit;
wire count_zero;
wire wrap;
wire req;
wire wr;
wire rd;
wire mapped;
wire sel_mode;
wire sel_status;
wire sel_ack;
wire sel_peek;
wire sel_evt_status;
wire sel_evt_enable;
wire sel_evt_clear;
wire ack_read;
wire mode_write;
wire enable_write;
wire clear_write;

// ==========================================================
// bus decode
// a request is taken only while no answer is out, so a held strobe is answered every other cycle
assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
assign wr = req & wb_we_i;
assign rd = req & ~wb_we_i;

// misaligned addresses and the one spare word are refused with an error and have no effect
assign mapped = (wb_adr_i[1:0] == 2'b00) & (wb_adr_i[4:2] != 3'b111);
assign sel_mode = mapped & (wb_adr_i[4:2] == 3'b000);
assign sel_status = mapped & (wb_adr_i[4:2] == 3'b001);
assign sel_ack = mapped & (wb_adr_i[4:2] == 3'b010);
assign sel_peek = mapped & (wb_adr_i[4:2] == 3'b011);
assign sel_evt_status = mapped & (wb_adr_i[4:2] == 3'b100);
assign sel_evt_enable = mapped & (wb_adr_i[4:2] == 3'b101);
assign sel_evt_clear = mapped & (wb_adr_i[4:2] == 3'b110);

assign ack_read = rd & sel_ack;
assign mode_write = wr & sel_mode;
assign enable_write = wr & sel_evt_enable & wb_sel_i[0];
assign clear_write = wr & sel_evt_clear & wb_sel_i[0] & wb_dat_i[0];

// ==========================================================
// byte lanes
genvar lane;
generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
        assign wmask[lane * 8 + 7:lane * 8] = {8{wb_sel_i[lane]}};
    end
endgenerate

assign mode_word = {6'h00, tick_interrupt_enable, timer_enable_bit, 4'h0, interval_limit};
assign next_mode = (mode_word & ~wmask) | (wb_dat_i & wmask);
assign value_word = {overflow_tally, interval_count};

// ==========================================================
// divided tick
// the prescaler freezes in debug so no partial period is lost
assign tick = (div_cnt == `ITT_DIV_LAST) & ~debug_halt_i;
assign count_zero = interval_count == 20'h00000;
assign at_limit = interval_count == interval_limit;
assign wrap = tick & running & at_limit;

always @(posedge clk_i) begin
    if (rst_i) begin
        div_cnt <= 4'h0;
    end else if (!debug_halt_i) begin
        div_cnt <= div_cnt + 4'h1;
    end
end

// ==========================================================
// counters
// a limit lowered below the current count lets the count run round through 2^20
always @* begin
    next_count = interval_count;
    next_running = running;
    if (count_zero) begin
        next_running = timer_enable_bit;
    end
    if (tick && running) begin
        if (at_limit) begin
            next_count = 20'h00000;
            next_running = timer_enable_bit;
        end else begin
            next_count = interval_count + 20'h00001;
        end
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        interval_count <= 20'h00000;
        running <= 1'b0;
    end else begin
        interval_count <= next_count;
        running <= next_running;
    end
end

// ==========================================================
// overflow tally and tick flag
always @* begin
    next_tally = overflow_tally;
    next_flag = tick_status_flag;
    if (ack_read) begin
        next_tally = 12'h000;
        next_flag = 1'b0;
    end
    // a wrap in the acknowledge cycle wins: the flag stays set and the new period counts once
    if (wrap) begin
        next_tally = next_tally + 12'h001;
        next_flag = 1'b1;
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        overflow_tally <= 12'h000;
        tick_status_flag <= 1'b0;
    end else begin
        overflow_tally <= next_tally;
        tick_status_flag <= next_flag;
    end
end

// ==========================================================
// sticky wrap event
// set wins over a clear written in the same cycle, so no wrap is lost
always @* begin
    next_evt_status = evt_status;
    if (clear_write) begin
        next_evt_status = 1'b0;
    end
    if (wrap) begin
        next_evt_status = 1'b1;
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        evt_status <= 1'b0;
    end else begin
        evt_status <= next_evt_status;
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        evt_enable <= 1'b0;
    end else if (enable_write) begin
        evt_enable <= wb_dat_i[0];
    end
end

// ==========================================================
// mode register
// only the byte lanes selected are taken; the counters are left running
always @(posedge clk_i) begin
    if (rst_i) begin
        interval_limit <= `ITT_LIMIT_RESET;
    end else if (mode_write) begin
        interval_limit <= next_mode[`ITT_LIMIT_MSB:0];
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        timer_enable_bit <= 1'b0;
    end else if (mode_write) begin
        timer_enable_bit <= next_mode[`ITT_EN_BIT];
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        tick_interrupt_enable <= 1'b0;
    end else if (mode_write) begin
        tick_interrupt_enable <= next_mode[`ITT_IEN_BIT];
    end
end

// ==========================================================
// read data
// the acknowledge read returns the value as it stood before its own clear
always @* begin
    next_rdata = 32'h00000000;
    if (rd && mapped) begin
        case (wb_adr_i[4:2])
            3'b000: next_rdata = mode_word;
            3'b001: next_rdata = {31'h00000000, tick_status_flag};
            3'b010: next_rdata = value_word;
            3'b011: next_rdata = value_word;
            3'b100: next_rdata = {31'h00000000, evt_status};
            3'b101: next_rdata = {31'h00000000, evt_enable};
            default: next_rdata = 32'h00000000;
        endcase
    end
end

// ==========================================================
// bus answer
always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
    end else begin
        wb_ack_o <= req & mapped;
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        wb_err_o <= 1'b0;
    end else begin
        wb_err_o <= req & ~mapped;
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        wb_dat_o <= 32'h00000000;
    end else begin
        wb_dat_o <= next_rdata;
    end
end

// ==========================================================
// interrupts
// the wrap term lets the line rise in the cycle after the wrap, not two cycles later
always @(posedge clk_i) begin
    if (rst_i) begin
        tick_irq_o <= 1'b0;
    end else begin
        tick_irq_o <= next_flag & tick_interrupt_enable;
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        event_irq_o <= 1'b0;
    end else begin
        event_irq_o <= next_evt_status & evt_enable;
    end
end

endmodule // itt_timer

// *** testbench/itt_timer_assertions.sv ***
// port checker of the interval tick timer
`timescale 1ns/1ps
module itt_chk (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [4:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire wb_err_o,
    input wire tick_irq_o
);
// ==========
// bus and register checks
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
wire rd = wb_ack_o && !wb_we_i;
wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
chk_err_pulse: assert property (wb_err_o |=> !wb_err_o) else $error("err held");
chk_answer_next: assert property (req |=> wb_ack_o || wb_err_o) else $error("no answer");
chk_err_unmapped: assert property (req && wb_adr_i[1:0] != 2'h0 |=> wb_err_o && !wb_ack_o) else $error("no err");
chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not idle");
chk_status_rsv: assert property (rd && wb_adr_i == 5'h04 |-> wb_dat_o[31:1] == 31'h0) else $error("status");
chk_mode_rsv: assert property (rd && wb_adr_i == 5'h00 |-> wb_dat_o[31:26] == 6'h0) else $error("mode");
// the clear and the output drop both land at the taking edge
chk_ack_clears: assert property (rd && wb_adr_i == 5'h08 |-> ##2 !tick_irq_o) else $error("irq kept");
endmodule // itt_chk

// *** testbench/tb.sv ***
// self-checking bench of the interval tick timer
`timescale 1ns/1ps
module tb;
reg clk_i = 0, rst_i = 1, cyc = 0, we = 0, dbg = 0;
reg [4:0] adr = 0;
reg [31:0] wd = 0;
reg [64:0] e;
wire [31:0] rdat;
wire ack, err, tirq, eirq;
integer failures = 0, total_checks = 0, seed = 79001, lim, t;
logic [64:0] q[$];
always #4 clk_i = ~clk_i;
itt_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .debug_halt_i(dbg),
    .tick_irq_o(tirq), .event_irq_o(eirq));
task chk(input string n, input [31:0] x, input [31:0] g);
    total_checks++;
    if (g !== x) begin
        failures++;
        $display("wrong value %s exp %h got %h", n, x, g);
    end
endtask
task bus(input [4:0] a, input w, input [31:0] d, input [64:0] x);
    @(posedge clk_i);
    cyc <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    if (!w) q.push_back(x);
    @(posedge clk_i);
    while (!(ack | err)) @(posedge clk_i);
    cyc <= 0;
endtask
task rd(input [4:0] a, input [31:0] m, input [31:0] x, input r);
    bus(a, 0, 0, {r, m, x});
endtask
task wr(input [4:0] a, input [31:0] d);
    bus(a, 1, d, 65'h0);
endtask
// ==========
// read watcher: masked data and error flag against the oldest note
always @(posedge clk_i) begin
    if ((ack | err) && !we) begin
        e = q.pop_front();
        chk("read data", e[31:0], rdat & e[63:32]);
        chk("bus error", {31'h0, e[64]}, {31'h0, err});
    end
end
task results;
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
endtask
initial begin
    #200000;
    failures++;
    results;
end
initial begin
    lim = 2 + ($random(seed) & 3);
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    rd(0, '1, 32'h000FFFFF, 0);
    rd(4, '1, 0, 0);
    rd(8, '1, 0, 0);
    rd(12, '1, 0, 0);
    rd(5'h1C, 0, 0, 1);
    rd(5'h02, 0, 0, 1);
    wr(5'h14, 1);
    wr(0, 32'h03000000 | lim);
    wait (tirq);
    t = 32'($time);
    rd(4, '1, 1, 0);
    rd(12, 32'hFFF00000, 32'h00100000, 0);
    rd(12, 32'hFFF00000, 32'h00100000, 0);
    rd(8, 32'hFFF00000, 32'h00100000, 0);
    rd(4, '1, 0, 0);
    wait (tirq);
    chk("period", (lim + 1) * 128, 32'($time) - t);
    // halt before the clearing read so no wrap can slip in between
    dbg <= 1;
    rd(8, 0, 0, 0);
    repeat (300) @(posedge clk_i);
    rd(12, 32'hFFF00000, 0, 0);
    chk("tick irq", 0, {31'h0, tirq});
    dbg <= 0;
    wr(0, lim);
    repeat ((lim + 1) * 64) @(posedge clk_i);
    rd(8, 0, 0, 0);
    repeat ((lim + 1) * 32) @(posedge clk_i);
    rd(8, '1, 0, 0);
    chk("event irq", 1, {31'h0, eirq});
    wr(5'h14, 0);
    @(posedge clk_i);
    chk("event irq", 0, {31'h0, eirq});
    rd(5'h10, 1, 1, 0);
    wr(5'h18, 1);
    rd(5'h10, 1, 0, 0);
    results;
end
endmodule // tb
bind itt_timer itt_chk i_chk (.*);
